// File: common/mpt_pkg.sv
package mpt_pkg;
  localparam int CLK_MHZ = 120;
  localparam int PWM_HZ = 20000;
  localparam logic signed [15:0] PERIOD_END_RST = 16'sh0bb8;
  localparam logic signed [15:0] CENTER_CMP = 16'sh0000;
  localparam logic signed [15:0] FALL_CMP_RST = 16'sh012c;
  localparam logic signed [15:0] RISE_CMP_RST = 16'shfed4;
  localparam int NUM_PHASES = 3;
  localparam int NUM_TRIG = 8;
  localparam logic [12:0] TRIG_CNT_MAX = 13'h1770;
  localparam logic [12:0] TRIG_RELOAD_RST = 13'h0000;
  localparam logic [12:0] TRIG0_CMP_RST = 13'h00b4;
  localparam logic [7:0] TRIG_EN_RST = 8'h01;
  localparam logic [4:0] CMD_START_RST = 5'h02;
  localparam int CMD_DEPTH = 24;
  localparam logic [4:0] CMD_LAST = 5'h17;
  localparam int NUM_SECTORS = 6;
  localparam logic [3:0] CH_BEMF_A = 4'hb;
  localparam logic [3:0] CH_BEMF_B = 4'hc;
  localparam logic [3:0] CH_BEMF_C = 4'hd;
  localparam logic [3:0] CH_DC_VOLT = 4'h0;
  localparam logic [3:0] CH_DC_CURR = 4'h2;

  typedef struct packed {
    logic first;
    logic dual;
    logic [3:0] chanA;
    logic [3:0] chanB;
  } mpt_cmd_t;

  typedef struct packed {
    logic valid;
    logic dual;
    logic [4:0] index;
    logic [3:0] chanA;
    logic [3:0] chanB;
  } mpt_conv_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_RUN = 2'b10
  } mpt_seq_t;
endpackage

// File: rtl/mpt_pwm_phase.sv
`timescale 1ns/1ps
module mpt_pwm_phase (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic masterReload,
  input wire logic signed [15:0] pwmCount,
  input wire logic signed [15:0] riseCmpBuf,
  input wire logic signed [15:0] fallCmpBuf,
  output logic pwmHigh,
  output logic pwmLow
);
  logic signed [15:0] riseCmp_reg;
  logic signed [15:0] fallCmp_reg;

  // Buffered compares become active only on the master reload
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      riseCmp_reg <= mpt_pkg::RISE_CMP_RST;
      fallCmp_reg <= mpt_pkg::FALL_CMP_RST;
    end
    else if (masterReload)
    begin
      riseCmp_reg <= riseCmpBuf;
      fallCmp_reg <= fallCmpBuf;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pwmHigh <= 1'b0;
      pwmLow <= 1'b0;
    end
    else
    begin
      // Output high between rising and falling compare around center
      pwmHigh <= (pwmCount >= riseCmp_reg) && (pwmCount < fallCmp_reg);
      pwmLow <= !((pwmCount >= riseCmp_reg) && (pwmCount < fallCmp_reg));
    end
  end

  a_buf_transfer: assert property (@(posedge ref_clk) disable iff (!rst_n)
    masterReload |=> riseCmp_reg == $past(riseCmpBuf))
    else $error("rise compare not loaded on reload");
  a_hold_between: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !masterReload |=> $stable(fallCmp_reg))
    else $error("fall compare changed without reload");
endmodule // mpt_pwm_phase

// File: rtl/mpt_motor_pwm.sv
`timescale 1ns/1ps
module mpt_motor_pwm (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic signed [15:0] periodEndCompare,
  input wire logic signed [15:0] risingEdgeCompare [mpt_pkg::NUM_PHASES],
  input wire logic signed [15:0] fallingEdgeCompare [mpt_pkg::NUM_PHASES],
  input wire logic triggerInputSelect,
  input wire logic [12:0] triggerCounterReload,
  input wire logic [12:0] triggerCompare [mpt_pkg::NUM_TRIG],
  input wire logic [7:0] triggerEnable,
  input wire logic [2:0] commutationSector,
  output logic [2:0] pwmHigh,
  output logic [2:0] pwmLow,
  output logic masterReloadEvent,
  output logic masterSync,
  output logic [7:0] triggerEvent,
  output logic [4:0] commandListPointer,
  output mpt_pkg::mpt_conv_t convCmd,
  output logic seqBusy
);
  logic signed [15:0] pwmCount_reg;
  logic signed [15:0] periodEnd_reg;
  logic [12:0] trigCount_reg;
  logic [12:0] trigReload_reg;
  logic [4:0] cmdIdx_reg;
  mpt_pkg::mpt_seq_t seqState_reg;
  mpt_pkg::mpt_cmd_t cmdList [mpt_pkg::CMD_DEPTH];
  logic masterReload;
  logic [4:0] sectorStart;
  logic [4:0] nextIdx;

  assign masterReload = (pwmCount_reg == periodEnd_reg);
  assign masterReloadEvent = masterReload;
  assign masterSync = masterReload;

  // Period end is double-buffered too, so a period never gets cut short
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      periodEnd_reg <= mpt_pkg::PERIOD_END_RST;
    else if (masterReload)
      periodEnd_reg <= periodEndCompare;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      pwmCount_reg <= -mpt_pkg::PERIOD_END_RST;
    else if (masterReload)
      pwmCount_reg <= -periodEndCompare;
    else
      pwmCount_reg <= pwmCount_reg + 16'sh0001;
  end

  genvar p;
  generate
    for (p = 0; p < mpt_pkg::NUM_PHASES; p++)
    begin : g_phase
      mpt_pwm_phase u_phase (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .masterReload(masterReload),
        .pwmCount(pwmCount_reg),
        .riseCmpBuf(risingEdgeCompare[p]),
        .fallCmpBuf(fallingEdgeCompare[p]),
        .pwmHigh(pwmHigh[p]),
        .pwmLow(pwmLow[p])
      );
    end
  endgenerate

  // Trigger scheduler: only the reload event, with triggerInputSelect set, restarts the count
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      trigReload_reg <= mpt_pkg::TRIG_RELOAD_RST;
    else if (masterReload)
      trigReload_reg <= triggerCounterReload;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      trigCount_reg <= mpt_pkg::TRIG_RELOAD_RST;
    else if (masterReload && triggerInputSelect)
      trigCount_reg <= trigReload_reg;
    else if (trigCount_reg != mpt_pkg::TRIG_CNT_MAX)
      trigCount_reg <= trigCount_reg + 13'h0001;
  end

  // Saturating at 6000 keeps a stalled input from retriggering on wrap
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      triggerEvent <= 8'h00;
    else
      for (int t = 0; t < mpt_pkg::NUM_TRIG; t++)
        triggerEvent[t] <= triggerEnable[t] && triggerInputSelect
                           && (trigCount_reg == triggerCompare[t]);
  end

  // Fixed command list; each sector's sequence starts at a first-marked entry
  always_comb
  begin
    for (int i = 0; i < mpt_pkg::CMD_DEPTH; i++)
      cmdList[i] = '{first: 1'b0, dual: 1'b0, chanA: 4'h0, chanB: 4'h0};
    cmdList[0].first = 1'b1;
    cmdList[2] = '{1'b1, 1'b1, mpt_pkg::CH_BEMF_C, mpt_pkg::CH_DC_VOLT};
    cmdList[3] = '{1'b0, 1'b1, mpt_pkg::CH_DC_VOLT, mpt_pkg::CH_DC_CURR};
    cmdList[4] = '{1'b1, 1'b1, mpt_pkg::CH_BEMF_B, mpt_pkg::CH_DC_VOLT};
    cmdList[5] = '{1'b0, 1'b1, mpt_pkg::CH_DC_VOLT, mpt_pkg::CH_DC_CURR};
    cmdList[6] = '{1'b1, 1'b1, mpt_pkg::CH_BEMF_A, mpt_pkg::CH_DC_VOLT};
    cmdList[7] = '{1'b0, 1'b1, mpt_pkg::CH_DC_VOLT, mpt_pkg::CH_DC_CURR};
    cmdList[8] = '{1'b1, 1'b1, mpt_pkg::CH_BEMF_C, mpt_pkg::CH_DC_VOLT};
    cmdList[9] = '{1'b0, 1'b1, mpt_pkg::CH_DC_VOLT, mpt_pkg::CH_DC_CURR};
    cmdList[10] = '{1'b1, 1'b1, mpt_pkg::CH_BEMF_B, mpt_pkg::CH_DC_VOLT};
    cmdList[11] = '{1'b0, 1'b1, mpt_pkg::CH_DC_VOLT, mpt_pkg::CH_DC_CURR};
    cmdList[12] = '{1'b1, 1'b1, mpt_pkg::CH_BEMF_A, mpt_pkg::CH_DC_VOLT};
    cmdList[13] = '{1'b0, 1'b1, mpt_pkg::CH_DC_VOLT, mpt_pkg::CH_DC_CURR};
    cmdList[14].first = 1'b1;
  end

  // Sectors 0 to 5 map to entries 2 to 12, two entries apart; sectors 6 and 7 fold back to entry 2
  always_comb
  begin
    if (commutationSector < 3'(mpt_pkg::NUM_SECTORS))
      sectorStart = mpt_pkg::CMD_START_RST + {1'b0, commutationSector, 1'b0};
    else
      sectorStart = mpt_pkg::CMD_START_RST;
  end

  // Pointer moves only on reload so a running sequence keeps its start
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      commandListPointer <= mpt_pkg::CMD_START_RST;
    else if (masterReload)
      commandListPointer <= sectorStart;
  end

  assign nextIdx = cmdIdx_reg + 5'h01;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      seqState_reg <= mpt_pkg::SEQ_IDLE;
      cmdIdx_reg <= mpt_pkg::CMD_START_RST;
    end
    else
      case (seqState_reg)
        mpt_pkg::SEQ_IDLE:
          if (triggerEvent[0])
          begin
            seqState_reg <= mpt_pkg::SEQ_RUN;
            cmdIdx_reg <= commandListPointer;
          end
        mpt_pkg::SEQ_RUN:
          if (cmdIdx_reg == mpt_pkg::CMD_LAST || cmdList[nextIdx].first)
            seqState_reg <= mpt_pkg::SEQ_IDLE;
          else
            cmdIdx_reg <= nextIdx;
        default:
          seqState_reg <= mpt_pkg::SEQ_IDLE;
      endcase
  end

  assign seqBusy = (seqState_reg == mpt_pkg::SEQ_RUN);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      convCmd <= '0;
    else
    begin
      convCmd.valid <= seqBusy;
      convCmd.dual <= cmdList[cmdIdx_reg].dual;
      convCmd.index <= cmdIdx_reg;
      convCmd.chanA <= cmdList[cmdIdx_reg].chanA;
      convCmd.chanB <= cmdList[cmdIdx_reg].chanB;
    end
  end

  a_reload_period: assert property (@(posedge ref_clk) disable iff (!rst_n)
    masterReload |=> pwmCount_reg == -$past(periodEndCompare))
    else $error("counter not restarted at negated period end");
  a_count_up: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !masterReload |=> pwmCount_reg == $past(pwmCount_reg) + 16'sh0001)
    else $error("pwm counter did not step up");
  // A missed reload would let the counter run on past the period end
  a_reload_match: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !masterReloadEvent |-> pwmCount_reg < periodEnd_reg)
    else $error("counter passed period end without reload");
  a_trig_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
    masterReload && triggerInputSelect |=> trigCount_reg == $past(trigReload_reg))
    else $error("trigger counter not reloaded");
  a_trig_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    trigCount_reg <= mpt_pkg::TRIG_CNT_MAX)
    else $error("trigger counter beyond maximum");
  a_trig_fire: assert property (@(posedge ref_clk) disable iff (!rst_n)
    triggerEnable[0] && triggerInputSelect && trigCount_reg == triggerCompare[0]
    |=> triggerEvent[0])
    else $error("trigger 0 missed its compare");
  a_seq_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !seqBusy && triggerEvent[0] |=> seqBusy && cmdIdx_reg == $past(commandListPointer))
    else $error("sequence did not start at pointer");
  a_seq_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
    seqBusy && cmdList[nextIdx].first |=> !seqBusy)
    else $error("sequence ran past first-marked entry");
  a_conv_dual: assert property (@(posedge ref_clk) disable iff (!rst_n)
    convCmd.valid && convCmd.index >= 5'h02 && convCmd.index <= 5'h0d |-> convCmd.dual)
    else $error("command 2 to 13 not dual");

  c_reload: cover property (@(posedge ref_clk) disable iff (!rst_n) masterReload);
  c_trig0: cover property (@(posedge ref_clk) disable iff (!rst_n) triggerEvent[0]);
  c_seq_done: cover property (@(posedge ref_clk) disable iff (!rst_n)
    seqBusy ##1 !seqBusy);
endmodule // mpt_motor_pwm

// File: tb/mpt_far_side_model.sv
`timescale 1ns/1ps
module mpt_far_side_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] pwmHigh,
  input wire logic [2:0] pwmLow,
  input wire mpt_pkg::mpt_conv_t convCmd,
  output logic [7:0] convCount,
  output logic overlap
);
  // Pre-driver latches a fault if any leg is driven high and low at once
  always @(negedge ref_clk)
  begin
    if (!rst_n)
    begin
      convCount <= 8'h00;
      overlap <= 1'b0;
    end
    else
    begin
      if ((pwmHigh & pwmLow) !== 3'h0)
        overlap <= 1'b1;
      // Both converters start together on a dual entry
      if (convCmd.valid === 1'b1 && convCmd.dual === 1'b1)
        convCount <= convCount + 8'h01;
    end
  end
endmodule // mpt_far_side_model

// File: tb/mpt_motor_pwm_tb.sv
`timescale 1ns/1ps
module mpt_motor_pwm_tb;
  logic ref_clk, rst_n, trigSel, reloadEv, syncEv, seqBusy, overlap;
  logic signed [15:0] periodEnd, newFall;
  logic signed [15:0] riseCmp [mpt_pkg::NUM_PHASES];
  logic signed [15:0] fallCmp [mpt_pkg::NUM_PHASES];
  logic [12:0] trigReload;
  logic [12:0] trigCmp [mpt_pkg::NUM_TRIG];
  logic [7:0] trigEn, trigEv, convCount;
  logic [2:0] sector, pwmHigh, pwmLow;
  logic [4:0] ptr;
  mpt_pkg::mpt_conv_t convCmd;
  mpt_pkg::mpt_conv_t conv[$];
  int n_mismatch = 0, num_checks = 0, len, cmpl, expConv = 0, busyCnt, nTrig0;
  int highCnt [3];
  int trigAt [8];
  bit midUpd = 0;
  int bemf [6] = '{13, 12, 11, 13, 12, 11};

  mpt_motor_pwm i_mpt_motor_pwm (.ref_clk(ref_clk), .rst_n(rst_n),
    .periodEndCompare(periodEnd), .risingEdgeCompare(riseCmp), .fallingEdgeCompare(fallCmp),
    .triggerInputSelect(trigSel), .triggerCounterReload(trigReload),
    .triggerCompare(trigCmp), .triggerEnable(trigEn), .commutationSector(sector),
    .pwmHigh(pwmHigh), .pwmLow(pwmLow), .masterReloadEvent(reloadEv), .masterSync(syncEv),
    .triggerEvent(trigEv), .commandListPointer(ptr), .convCmd(convCmd), .seqBusy(seqBusy));

  mpt_far_side_model i_mpt_far_side_model (.ref_clk(ref_clk), .rst_n(rst_n), .pwmHigh(pwmHigh),
    .pwmLow(pwmLow), .convCmd(convCmd), .convCount(convCount), .overlap(overlap));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
      n_mismatch++;
    end
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task set_duty(input logic signed [15:0] f0, input logic signed [15:0] f1,
                input logic signed [15:0] f2);
    fallCmp = '{f0, f1, f2};
    riseCmp = '{-f0, -f1, -f2};
  endtask

  // Measures one reload-to-reload span; outputs are sampled on the falling edge
  task run_period;
    int k;
    @(negedge ref_clk);
    for (k = 0; k < 7000 && reloadEv !== 1'b1; k++)
      @(negedge ref_clk);
    check("reload", {31'h0, reloadEv}, 32'h1);
    check("sync", {31'h0, syncEv}, 32'h1);
    len = 0;
    cmpl = 0;
    busyCnt = 0;
    nTrig0 = 0;
    highCnt = '{0, 0, 0};
    trigAt = '{-1, -1, -1, -1, -1, -1, -1, -1};
    conv.delete();
    do
    begin
      @(negedge ref_clk);
      len++;
      for (int i = 0; i < 3; i++)
        highCnt[i] += (pwmHigh[i] === 1'b1);
      if (pwmLow !== ~pwmHigh)
        cmpl++;
      for (int t = 0; t < 8; t++)
        if (trigEv[t] === 1'b1 && trigAt[t] < 0)
          trigAt[t] = len;
      if (convCmd.valid === 1'b1)
        conv.push_back(convCmd);
      busyCnt += (seqBusy === 1'b1);
      nTrig0 += (trigEv[0] === 1'b1);
      // Late write lands inside the period after this cycle has been sampled
      if (midUpd && len == 5)
      begin
        @(posedge ref_clk);
        #1 set_duty(newFall, newFall, newFall);
      end
    end
    while (reloadEv !== 1'b1 && len < 7000);
  endtask

  task check_duty(input int h0, input int h1, input int h2);
    check("high0", highCnt[0], h0);
    check("high1", highCnt[1], h1);
    check("high2", highCnt[2], h2);
    check("complement", cmpl, 0);
  endtask

  initial
  begin
    rst_n = 1'b0;
    periodEnd = 16'sh012c;
    set_duty(16'sh012c, 16'sh0096, 16'sh003c);
    trigSel = 1'b1;
    trigReload = 13'h0000;
    trigCmp = '{13'h00b4, 13'h0032, 13'h0, 13'h0, 13'h0, 13'h0, 13'h0, 13'h0};
    trigEn = 8'h01;
    sector = 3'h0;
    repeat (2) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    for (int s = 0; s < 6; s++)
    begin
      @(posedge ref_clk);
      #1 sector = 3'(s);
      // Buffered reload value steers the counter only from the reload after next
      if (s == 5)
        trigReload = 13'h0014;
      run_period();
      // Each call spans a waiting and a measured period, each with one sequence
      expConv += 4;
      check("period", len, 601);
      check_duty(600, 300, 120);
      check("trig0 once", nTrig0, 1);
      check("busy", busyCnt, 2);
      check("trig0", trigAt[0], 182);
      check("trig1 off", trigAt[1], 32'hffffffff);
      check("pointer", ptr, 2 + 2 * s);
      check("entries", conv.size(), 2);
      check("idx0", conv[0].index, 2 + 2 * s);
      check("dual", {conv[0].dual, conv[1].dual}, 2'b11);
      check("bemf", conv[0].chanA, bemf[s]);
      check("volt", conv[0].chanB, 0);
      check("idx1", conv[1].index, 3 + 2 * s);
      check("curr", conv[1].chanB, 2);
      $display("test sector %0d done", s);
    end
    // New duty written mid-period must wait for the next reload
    @(posedge ref_clk);
    #1 trigEn = 8'h03;
    trigReload = 13'h0014;
    newFall = 16'sh0032;
    midUpd = 1;
    run_period();
    expConv += 4;
    midUpd = 0;
    check_duty(600, 300, 120);
    check("trig0 reload", trigAt[0], 162);
    check("trig1", trigAt[1], 32);
    @(posedge ref_clk);
    #1 periodEnd = 16'sh00c8;
    trigSel = 1'b0;
    sector = 3'h6;
    run_period();
    check_duty(100, 100, 100);
    check("pointer fold", ptr, 2);
    check("busy off", busyCnt, 0);
    check("period new", len, 401);
    check("no trig", trigAt[0], 32'hffffffff);
    check("no conv", conv.size(), 0);
    $display("test buffering done");
    check("conv total", convCount, expConv);
    check("overlap", overlap, 0);
    report_and_stop();
  end

  initial
  begin
    #300000;
    n_mismatch++;
    report_and_stop();
  end
endmodule // mpt_motor_pwm_tb
